// *** src/gpio_wake_and_reset_out.sv ***
// multifunction pin, gpio bank and wake logic with register port
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module gpio_wake_and_reset_out (
    input wire logic mclk,
    input wire logic arst_n,
    // register port
    input wire logic [gpio_wake_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_wake_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpio_wake_pkg::DATA_W-1:0] reg_rdata,
    // power manager, same clock domain
    input wire logic powerup_done,
    input wire logic soft_reboot,
    input wire logic sleep_state,
    input wire logic deep_lowpower_state,
    input wire logic deep_power_off_state,
    input wire logic timer_wake,
    // multifunction pin
    input wire logic multifunction_pin_i,
    output logic multifunction_pin_o,
    output logic multifunction_pin_oe,
    // wake pins a..e in bits 0..4
    input wire logic [4:0] wake_pin_i,
    output logic [4:0] wake_pin_o,
    output logic [4:0] wake_pin_oe,
    // pins 28..31 in bits 0..3
    input wire logic [3:0] ext_pin_i,
    output logic [3:0] ext_pin_o,
    output logic [3:0] ext_pin_oe,
    // other wake inputs from pins
    input wire logic terminal_ready_in,
    input wire logic card_detect_in,
    input wire logic analog_wake_a,
    input wire logic analog_wake_b,
    input wire logic power_key_n,
    // results
    output logic sleep_wake_req,
    output logic deep_wake_req,
    output logic irq
);
    import gpio_wake_pkg::*;

    // ****************************************************************
    // registers and state
    // ****************************************************************
    logic sim_sw_q;
    logic sim_sel_q;
    logic [7:0] mf_cfg_q;
    mf_func_t active_q;
    logic [GPIO_N-1:0] dir_q;
    logic [GPIO_N-1:0] out_q;
    logic [3:0] ext_en_q;
    logic [4:0] sleep_en_q;
    logic [6:0] deep_en_q;
    logic [IRQ_N-1:0] stat_q;
    logic [IRQ_N-1:0] stat_d;
    logic [IRQ_N-1:0] mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic pwr_done_q;
    logic card_prev_q;
    logic mf_o_q;
    logic mf_oe_q;
    logic [4:0] wk_o_q;
    logic [4:0] wk_oe_q;
    logic [3:0] ext_o_q;
    logic [3:0] ext_oe_q;
    logic irq_q;

    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    logic [SYNC_N-1:0] sync_w;

    // every pin passes two flops before use
    pin_sync #(
        .W(SYNC_N)
    ) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .async_i({~power_key_n, analog_wake_b, analog_wake_a, card_detect_in,
                  terminal_ready_in, ext_pin_i, wake_pin_i,
                  multifunction_pin_i}),
        .sync_o(sync_w)
    );

    wire mf_s = sync_w[0];
    wire [4:0] wk_s = sync_w[5:1];
    wire [3:0] ext_s = sync_w[9:6];
    wire term_s = sync_w[10];
    wire card_s = sync_w[11];
    wire adc_a_s = sync_w[12];
    wire adc_b_s = sync_w[13];
    wire pkey_s = sync_w[14]; // pressed level, idles low like reset
    wire [GPIO_N-1:0] gpio_in_w = {ext_s, wk_s, mf_s};

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
    wire wr_mf = reg_wr & (reg_addr == OFS_MF_CFG);
    wire wr_dir = reg_wr & (reg_addr == OFS_DIR);
    wire wr_out = reg_wr & (reg_addr == OFS_OUT);
    wire wr_ext = reg_wr & (reg_addr == OFS_EXT_EN);
    wire wr_sleep = reg_wr & (reg_addr == OFS_SLEEP_EN);
    wire wr_deep = reg_wr & (reg_addr == OFS_DEEP_EN);
    wire wr_mask = reg_wr & (reg_addr == OFS_IRQ_MASK);
    wire rd_stat = reg_rd & (reg_addr == OFS_IRQ_STAT);

    // ****************************************************************
    // multifunction selection
    // ****************************************************************
    // sim switching overrides the pin configuration argument
    mf_func_t sel_w;
    always_comb begin
        if (sim_sw_q) begin
            sel_w = FUNC_SIM_SWITCH;
        end else if (mf_cfg_q == MF_ARG_GPIO) begin
            sel_w = FUNC_GPIO;
        end else begin
            sel_w = FUNC_RESET_OUT;
        end
    end

    // only the two documented arguments are accepted
    wire mf_arg_ok = (reg_wdata[7:0] == MF_ARG_GPIO) |
                     (reg_wdata[7:0] == MF_ARG_RESET);

    // ****************************************************************
    // wake detection
    // ****************************************************************
    logic sleep_flag_w;
    logic sleep_req_w;
    logic deep_flag_w;
    logic deep_req_w;

    // sleep sources: five pins, terminal ready, card detect
    wake_detect #(
        .W(7)
    ) u_sleep_wake (
        .mclk(mclk),
        .arst_n(arst_n),
        .sig_i({card_s, term_s, wk_s}),
        .en_i({2'b11, sleep_en_q}),
        .armed_i(sleep_state),
        .flag_o(sleep_flag_w),
        .req_o(sleep_req_w)
    );

    // deep sources: timer, pins a c d e, two analog, power key
    wake_detect #(
        .W(8)
    ) u_deep_wake (
        .mclk(mclk),
        .arst_n(arst_n),
        .sig_i({pkey_s, adc_b_s, adc_a_s, wk_s[4], wk_s[3], wk_s[2],
                wk_s[0], timer_wake}),
        .en_i({1'b1, deep_en_q}),
        .armed_i(deep_lowpower_state),
        .flag_o(deep_flag_w),
        .req_o(deep_req_w)
    );

    // ****************************************************************
    // interrupt status
    // ****************************************************************
    // card detect rises on insertion, falls on removal
    wire card_in_ev = card_s & ~card_prev_q;
    wire card_out_ev = ~card_s & card_prev_q;
    wire pwr_done_ev = powerup_done & ~pwr_done_q;
    wire [IRQ_N-1:0] ev_w = {pwr_done_ev, card_out_ev, card_in_ev,
                             deep_req_w, sleep_req_w};

    // read clears, a new event in the same cycle wins
    always_comb begin
        stat_d = rd_stat ? ev_w : (stat_q | ev_w);
    end

    // ****************************************************************
    // pin drive
    // ****************************************************************
    // no pull is ever enabled; an undriven pin simply floats
    logic mf_o_d;
    logic mf_oe_d;
    always_comb begin
        case (active_q)
            FUNC_GPIO: begin
                mf_o_d = out_q[0];
                mf_oe_d = dir_q[0];
            end
            FUNC_SIM_SWITCH: begin
                mf_o_d = sim_sel_q;
                mf_oe_d = 1'b1;
            end
            FUNC_RESET_OUT: begin
                mf_o_d = powerup_done;
                mf_oe_d = 1'b1;
            end
            default: begin
                mf_o_d = 1'b0;
                mf_oe_d = 1'b0;
            end
        endcase
    end

    // deep power-off releases every pin, reset output included
    wire drive_ok = ~deep_power_off_state;
    wire [3:0] ext_oe_d = dir_q[9:6] & ext_en_q;

    // ****************************************************************
    // read mux
    // ****************************************************************
    logic [DATA_W-1:0] rmux_w;
    always_comb begin
        case (reg_addr)
            OFS_CTRL: rmux_w = {30'h0, sim_sel_q, sim_sw_q};
            OFS_MF_CFG: rmux_w = {22'h0, active_q, mf_cfg_q};
            OFS_DIR: rmux_w = {22'h0, dir_q};
            OFS_OUT: rmux_w = {22'h0, out_q};
            OFS_IN: rmux_w = {22'h0, gpio_in_w};
            OFS_EXT_EN: rmux_w = {28'h0, ext_en_q};
            OFS_SLEEP_EN: rmux_w = {27'h0, sleep_en_q};
            OFS_DEEP_EN: rmux_w = {25'h0, deep_en_q};
            OFS_IRQ_STAT: rmux_w = {27'h0, stat_q};
            OFS_IRQ_MASK: rmux_w = {27'h0, mask_q};
            OFS_STATE: rmux_w = {26'h0, deep_flag_w, sleep_flag_w,
                                 powerup_done, sel_w, pwr_done_q};
            default: rmux_w = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    // software settings
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sim_sw_q <= 1'b0;
            sim_sel_q <= 1'b0;
            mf_cfg_q <= MF_CFG_RST;
            dir_q <= DIR_RST;
            out_q <= OUT_RST;
            ext_en_q <= EXT_EN_RST;
            sleep_en_q <= SLEEP_EN_RST;
            deep_en_q <= DEEP_EN_RST;
            mask_q <= IRQ_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                sim_sw_q <= reg_wdata[CTRL_SIM_SW_BIT];
                sim_sel_q <= reg_wdata[CTRL_SIM_SEL_BIT];
            end
            if (wr_mf && mf_arg_ok) begin
                mf_cfg_q <= reg_wdata[7:0];
            end
            if (wr_dir) begin
                dir_q <= reg_wdata[GPIO_N-1:0];
            end
            if (wr_out) begin
                out_q <= reg_wdata[GPIO_N-1:0];
            end
            if (wr_ext) begin
                ext_en_q <= reg_wdata[3:0];
            end
            if (wr_sleep) begin
                sleep_en_q <= reg_wdata[4:0];
            end
            if (wr_deep) begin
                deep_en_q <= reg_wdata[6:0];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[IRQ_N-1:0];
            end
        end
    end

    // active function changes only on reboot
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= FUNC_RESET_OUT;
        end else if (soft_reboot) begin
            active_q <= sel_w;
        end
    end

    // status, edge history, read data, interrupt
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
            card_prev_q <= 1'b0;
            pwr_done_q <= 1'b0;
            rdata_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            card_prev_q <= card_s;
            pwr_done_q <= powerup_done;
            rdata_q <= reg_rd ? rmux_w : 32'h0000_0000;
            irq_q <= |(stat_d & mask_q);
        end
    end

    // pin output flops; reset holds the reset output low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mf_o_q <= 1'b0;
            mf_oe_q <= 1'b1;
            wk_o_q <= '0;
            wk_oe_q <= '0;
            ext_o_q <= '0;
            ext_oe_q <= '0;
        end else begin
            mf_o_q <= mf_o_d;
            mf_oe_q <= mf_oe_d & drive_ok;
            wk_o_q <= out_q[5:1];
            wk_oe_q <= dir_q[5:1] & {5{drive_ok}};
            ext_o_q <= out_q[9:6];
            ext_oe_q <= ext_oe_d & {4{drive_ok}};
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = rdata_q;
    assign multifunction_pin_o = mf_o_q;
    assign multifunction_pin_oe = mf_oe_q;
    assign wake_pin_o = wk_o_q;
    assign wake_pin_oe = wk_oe_q;
    assign ext_pin_o = ext_o_q;
    assign ext_pin_oe = ext_oe_q;
    assign sleep_wake_req = sleep_req_w;
    assign deep_wake_req = deep_req_w;
    assign irq = irq_q;

endmodule : gpio_wake_and_reset_out

// *** src/gpio_wake_pkg.sv ***
// constants, types and register map of the pin and wake block
//
// Overview of operation
// - general-purpose pins never enable an internal pull; undriven pins stay unpulled.
// - multifunction pin offers exactly three functions: gpio, sim switching, reset out.
// - sim switch setting written 1, then reboot, makes the multifunction pin do sim switching.
// - sim switch 0, pin config argument 4, then reboot gives general-purpose io.
// - sim switch 0, pin config argument 0, then reboot gives reset output.
// - reset-output mode drives the pin low during reset and power-up.
// - reset-output mode drives the pin high once power-on sequence is complete.
// - in deep power-off the reset output floats; board supplies any pull.
// - pins 28 to 31 act as gpio only after pin config enables them; the enable gates only their output drive, their inputs read at any time.
// - only five wake pins, terminal ready and card detect wake from sleep.
// - a general-purpose pin wakes the device only once enabled as wake source.
// - in sleep, any rising or falling edge on a monitored pin wakes.
// - deep low-power wakes: timer, four pins, two analog inputs, power key always.
// - deep sources act only in deep low-power; sleep pins only in sleep.
package gpio_wake_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int GPIO_N = 10; // 0 multifunction, 1..5 wake a..e, 6..9 pins 28..31
    localparam int SYNC_N = 15;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MF_CFG = 8'h04;
    localparam logic [7:0] OFS_DIR = 8'h08;
    localparam logic [7:0] OFS_OUT = 8'h0c;
    localparam logic [7:0] OFS_IN = 8'h10;
    localparam logic [7:0] OFS_EXT_EN = 8'h14;
    localparam logic [7:0] OFS_SLEEP_EN = 8'h18;
    localparam logic [7:0] OFS_DEEP_EN = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_STATE = 8'h28;

    // field positions
    localparam int CTRL_SIM_SW_BIT = 0;
    localparam int CTRL_SIM_SEL_BIT = 1;
    localparam int IRQ_SLEEP_WAKE = 0;
    localparam int IRQ_DEEP_WAKE = 1;
    localparam int IRQ_CARD_IN = 2;
    localparam int IRQ_CARD_OUT = 3;
    localparam int IRQ_PWR_DONE = 4;
    localparam int IRQ_N = 5;

    // pin configuration arguments for the multifunction pin
    localparam logic [7:0] MF_ARG_GPIO = 8'h04;
    localparam logic [7:0] MF_ARG_RESET = 8'h00;

    // reset values
    localparam logic [7:0] MF_CFG_RST = 8'h00;
    localparam logic [GPIO_N-1:0] DIR_RST = 10'h000;
    localparam logic [GPIO_N-1:0] OUT_RST = 10'h000;
    localparam logic [3:0] EXT_EN_RST = 4'h0;
    localparam logic [4:0] SLEEP_EN_RST = 5'h00;
    localparam logic [6:0] DEEP_EN_RST = 7'h00;
    localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 5'h00;

    typedef enum logic [1:0] {
        FUNC_GPIO,
        FUNC_SIM_SWITCH,
        FUNC_RESET_OUT
    } mf_func_t;

endpackage : gpio_wake_pkg

// *** src/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : pin_sync

// *** src/wake_detect.sv ***
// transition detector with latched wake flag and single request pulse
`timescale 1ns/1ps
module wake_detect #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [W-1:0] sig_i,
    input wire logic [W-1:0] en_i,
    input wire logic armed_i,
    output logic flag_o,
    output logic req_o
);
    logic [W-1:0] prev_q;
    logic flag_q;
    logic req_q;
    wire hit = armed_i & (|((sig_i ^ prev_q) & en_i));

    // flag holds while armed, drops once the state is left
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= '0;
            flag_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            prev_q <= sig_i;
            flag_q <= armed_i & (flag_q | hit);
            req_q <= hit & ~flag_q;
        end
    end

    assign flag_o = flag_q;
    assign req_o = req_q;
endmodule : wake_detect

// *** sim/gpio_wake_chk.sv ***
// checker of reset output, pin release and wake request timing
`timescale 1ns/1ps
module gpio_wake_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic powerup_done,
    input wire logic soft_reboot,
    input wire logic sleep_state,
    input wire logic deep_lowpower_state,
    input wire logic deep_power_off_state,
    input wire logic terminal_ready_in,
    input wire logic power_key_n,
    input wire logic multifunction_pin_o,
    input wire logic multifunction_pin_oe,
    input wire logic [4:0] wake_pin_oe,
    input wire logic [3:0] ext_pin_oe,
    input wire logic sleep_wake_req,
    input wire logic deep_wake_req
);
    logic rst_fn_q;
    logic sw_q;
    logic dw_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // reset-out mode until any reboot; wake flags per armed period
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_fn_q <= 1'b1;
            sw_q <= 1'b0;
            dw_q <= 1'b0;
        end else begin
            rst_fn_q <= rst_fn_q && !soft_reboot;
            sw_q <= sleep_state && (sw_q || sleep_wake_req);
            dw_q <= deep_lowpower_state && (dw_q || deep_wake_req);
        end
    end
    sequence tr_edge;
        $changed(terminal_ready_in) && sleep_state && !sw_q;
    endsequence
    sequence key_edge;
        $changed(power_key_n) && deep_lowpower_state && !dw_q;
    endsequence
    a_reset_out_level: assert property (
        $past(rst_fn_q && !soft_reboot && !deep_power_off_state) |->
        multifunction_pin_o == $past(powerup_done) && multifunction_pin_oe)
        else $error("reset output level wrong");
    a_off_pins_float: assert property (
        deep_power_off_state |=> !multifunction_pin_oe &&
        wake_pin_oe == 5'h00 && ext_pin_oe == 4'h0)
        else $error("pin driven in deep power-off");
    a_sleep_req_pulse: assert property (
        sleep_wake_req |=> !sleep_wake_req)
        else $error("sleep wake request longer than one cycle");
    a_deep_req_pulse: assert property (
        $rose(deep_wake_req) |=> !deep_wake_req)
        else $error("deep wake request longer than one cycle");
    a_sleep_req_armed: assert property (
        sleep_wake_req |-> $past(sleep_state))
        else $error("sleep wake outside sleep");
    a_deep_req_armed: assert property (
        deep_wake_req |-> $past(deep_lowpower_state))
        else $error("deep wake outside deep low-power");
    a_ready_wakes_sleep: assert property (
        tr_edge |-> ##[1:4] (sleep_wake_req || sw_q || !sleep_state))
        else $error("terminal ready edge gave no wake");
    a_key_wakes_deep: assert property (
        key_edge |-> ##[1:4] (deep_wake_req || dw_q ||
        !deep_lowpower_state))
        else $error("power key edge gave no wake");
endmodule : gpio_wake_chk
bind gpio_wake_and_reset_out gpio_wake_chk i_gpio_wake_chk (
    .mclk, .arst_n, .powerup_done, .soft_reboot, .sleep_state,
    .deep_lowpower_state, .deep_power_off_state, .terminal_ready_in,
    .power_key_n, .multifunction_pin_o, .multifunction_pin_oe,
    .wake_pin_oe, .ext_pin_oe, .sleep_wake_req, .deep_wake_req);

// *** sim/board_model.sv ***
// host board model: pin wires, host drivers and card holder
`timescale 1ns/1ps
module board_model (
    input wire logic mclk,
    input wire logic pwr_off,
    input wire logic [9:0] pin_o,
    input wire logic [9:0] pin_oe,
    input wire logic [9:0] host_val,
    input wire logic card_present,
    output logic [9:0] pin_lvl,
    output logic card_det
);
    logic float_q = 1'b0;
    // unpulled wires wander when nobody drives them
    always @(posedge mclk) begin
        float_q <= ~float_q;
    end
    // host lets go of every pin in deep power-off
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_o[i] :
                (pwr_off ? float_q : host_val[i]);
        end
    end
    // holder switch reads high while a card sits in it
    assign card_det = card_present;
endmodule : board_model

// *** sim/gpio_wake_and_reset_out_tb.sv ***
// self-checking bench of the pin, reset output and wake block
`timescale 1ns/1ps
module gpio_wake_and_reset_out_tb;
    import gpio_wake_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic powerup_done = 1'b0;
    logic soft_reboot = 1'b0;
    logic sleep_state = 1'b0;
    logic deep_lowpower_state = 1'b0;
    logic deep_power_off_state = 1'b0;
    logic [10:0] src_q = 11'h400; // power key idles high
    logic [31:0] reg_rdata, v;
    logic mf_o, mf_oe, sleep_wake_req, deep_wake_req, irq, card_det;
    logic [4:0] wk_o, wk_oe;
    logic [3:0] ex_o, ex_oe;
    logic [9:0] lvl;
    int error_cnt = 0;
    int samples_checked = 0;
    int ns, nd;
    int dsrc[8] = '{7, 0, 2, 3, 4, 8, 9, 10};
    always #2.5 mclk = ~mclk;
    gpio_wake_and_reset_out i_gpio_wake_and_reset_out (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .powerup_done(powerup_done),
        .soft_reboot(soft_reboot), .sleep_state(sleep_state),
        .deep_lowpower_state(deep_lowpower_state),
        .deep_power_off_state(deep_power_off_state),
        .timer_wake(src_q[7]), .multifunction_pin_i(lvl[0]),
        .multifunction_pin_o(mf_o), .multifunction_pin_oe(mf_oe),
        .wake_pin_i(lvl[5:1]), .wake_pin_o(wk_o), .wake_pin_oe(wk_oe),
        .ext_pin_i(lvl[9:6]), .ext_pin_o(ex_o), .ext_pin_oe(ex_oe),
        .terminal_ready_in(src_q[5]), .card_detect_in(card_det),
        .analog_wake_a(src_q[8]), .analog_wake_b(src_q[9]),
        .power_key_n(src_q[10]), .sleep_wake_req(sleep_wake_req),
        .deep_wake_req(deep_wake_req), .irq(irq));
    board_model i_board_model (
        .mclk(mclk), .pwr_off(deep_power_off_state),
        .pin_o({ex_o, wk_o, mf_o}), .pin_oe({ex_oe, wk_oe, mf_oe}),
        .host_val({4'h0, src_q[4:0], 1'b0}), .card_present(src_q[6]),
        .pin_lvl(lvl), .card_det(card_det));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic reboot;
        @(posedge mclk);
        soft_reboot <= 1'b1;
        @(posedge mclk);
        soft_reboot <= 1'b0;
    endtask : reboot
    // arm a state, toggle one source twice, count requests after each; the second toggle must give none
    task automatic go(input int s, input logic [6:0] en, input logic slp,
            input logic dp, input int es, input int ed);
        wr(OFS_SLEEP_EN, {27'h0, en[4:0]});
        wr(OFS_DEEP_EN, {25'h0, en});
        @(posedge mclk);
        sleep_state <= slp;
        deep_lowpower_state <= dp;
        repeat (3) @(posedge mclk);
        for (int k = 0; k < 2; k++) begin
            src_q[s] <= ~src_q[s];
            ns = 0;
            nd = 0;
            repeat (10) begin
                @(negedge mclk);
                ns += (sleep_wake_req === 1'b1) ? 1 : 0;
                nd += (deep_wake_req === 1'b1) ? 1 : 0;
            end
            @(posedge mclk);
            chk(ns, (k == 0) ? es : 0);
            chk(nd, (k == 0) ? ed : 0);
        end
        sleep_state <= 1'b0;
        deep_lowpower_state <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : go
    task automatic results;
        $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // hang guard
    initial begin
        #200000;
        error_cnt++;
        results();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk({mf_oe, mf_o}, 2'b10);
        @(posedge mclk);
        powerup_done <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk({mf_oe, mf_o}, 2'b11);
        rd(OFS_IRQ_STAT, v);
        chk(v, 32'h10);
        rd(8'h40, v);
        chk(v, 32'h0);
        wr(OFS_DIR, 32'h042);
        wr(OFS_OUT, 32'h042);
        repeat (2) @(posedge mclk);
        #1;
        chk(ex_oe, 4'h0);
        wr(OFS_EXT_EN, 32'h1);
        repeat (4) @(posedge mclk);
        #1;
        chk({wk_oe, wk_o, ex_oe, ex_o}, 18'h02111);
        rd(OFS_IN, v);
        chk(v[6], 1'b1);
        @(posedge mclk);
        deep_power_off_state <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk({mf_oe, wk_oe, ex_oe}, 10'h000);
        @(posedge mclk);
        deep_power_off_state <= 1'b0;
        wr(OFS_DIR, 32'h040);
        wr(OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 7; i++) begin
            go(i, (i < 5) ? 7'(1 << i) : 7'h00, 1'b1, 1'b0, 1, 0);
        end
        #1;
        chk(irq, 1'b1);
        rd(OFS_IRQ_STAT, v);
        chk(v, 32'h0d);
        @(posedge mclk);
        #1;
        chk(irq, 1'b0);
        go(0, 7'h00, 1'b1, 1'b0, 0, 0);
        go(7, 7'h7f, 1'b1, 1'b0, 0, 0);
        go(5, 7'h7f, 1'b0, 1'b1, 0, 0);
        go(1, 7'h7f, 1'b0, 1'b1, 0, 0);
        for (int i = 0; i < 8; i++) begin
            go(dsrc[i], (i < 7) ? 7'(1 << i) : 7'h00,
               1'b0, 1'b1, 0, 1);
        end
        #1;
        chk(irq, 1'b0);
        rd(OFS_IRQ_STAT, v);
        chk(v, 32'h02);
        wr(OFS_CTRL, 32'h3);
        rd(OFS_MF_CFG, v);
        chk(v, 32'h200);
        reboot();
        rd(OFS_MF_CFG, v);
        chk({v[9:8], mf_oe, mf_o}, 4'h7);
        wr(OFS_CTRL, 32'h1);
        @(posedge mclk);
        #1;
        chk(mf_o, 1'b0);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_MF_CFG, 32'h4);
        reboot();
        wr(OFS_DIR, 32'h1);
        wr(OFS_OUT, 32'h1);
        wr(OFS_MF_CFG, 32'h6);
        rd(OFS_MF_CFG, v);
        chk({v[9:0], mf_oe, mf_o}, 12'h013);
        wr(OFS_MF_CFG, 32'h0);
        reboot();
        rd(OFS_MF_CFG, v);
        chk({v[9:0], mf_oe, mf_o}, 12'h803);
        results();
    end
endmodule : gpio_wake_and_reset_out_tb
